// file: design/node_cfg.sv
// APB register bank holding the configuration of a wireless fieldbus I/O node.
// Contract
// - On fieldbus loss, outputs clear or hold per fault action; clear is default.
// - Software fault mode picks clear, hold or set from a software-written field.
// - Input size 0..128 in steps of 16; default 128.
// - Output size 0..128 in steps of 16, valve points included.
// - Valve size 0..32 in steps of 8; default 32.
// - Effective valve points never exceed the output size.
// - Wireless idle drops the link; active, the default, runs it.
// - Address order mode 1 numbers from end plate; mode 2 from wireless unit.
// - Mapping is always automatic; no other choice exists.
// - System sizes are read only, derived from the automatic map.
// - Diagnostic allocation selects none, simple or detailed.
// - Max remotes is 0, 15 or 31; only that many channels valid.
// - Refresh period is one of nine listed values; default 1 s.
// - New remotes register only while pairing is enabled; default disabled.
// - Tag holds at most 15 single-byte characters; defaults to product text.
// - Diagnostics, when selected, lead the input data of the image.
// - Pairing change acts only after module reset command or power cycle; presetn clears the pending bit, so only the reset command applies it.
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/1ps
module node_cfg (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fieldbus_ok_pin,
    input wire logic [7:0] remote_io_in_points,
    input wire logic [7:0] remote_io_out_points,
    output logic outputs_clear,
    output logic outputs_hold,
    output logic outputs_set,
    output logic wireless_enable,
    output logic address_order_mode2,
    output logic [1:0] diag_alloc,
    output logic [7:0] diag_input_offset,
    output logic [30:0] channel_valid,
    output logic [3:0] refresh_sel,
    output logic pairing_active,
    output logic [7:0] valve_effective
);
    import node_cfg_pkg::*;

    logic [1:0] output_fault_action;
    logic [1:0] soft_action;
    logic [7:0] input_size;
    logic [7:0] output_size;
    logic [7:0] valve_size;
    logic wireless_active;
    logic order_mode2;
    logic [1:0] diag_sel;
    logic [4:0] max_remotes;
    logic [3:0] refresh_code;
    logic pairing_pending;
    logic pairing_applied;
    logic [31:0] tag_mem [tag_words];
    logic bus_sync1;
    logic bus_ok;
    logic [8:0] sys_in;
    logic [8:0] sys_out;
    logic wr;
    logic rd;
    logic known;
    logic factory;
    logic reset_module;
    logic [31:0] next_rdata;
    logic [7:0] in_req;
    logic [7:0] out_req;
    logic [7:0] valve_req;
    logic in_ok;
    logic out_ok;
    logic valve_ok;

    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign known = paddr == off_action || paddr == off_sizes || paddr == off_system
        || paddr == off_control || paddr == off_status || paddr == off_sys_size
        || (paddr >= off_tag0 && paddr < off_tag0 + 8'(4 * tag_words) && paddr[1:0] == 2'b00);
    assign factory = wr && paddr == off_control && pwdata[0];
    assign reset_module = wr && paddr == off_control && pwdata[1];
    assign in_req = pwdata[7:0];
    assign out_req = pwdata[15:8];
    assign valve_req = pwdata[23:16];
    assign in_ok = in_req <= io_max && (in_req & (io_step - 8'h01)) == 8'h00;
    assign out_ok = out_req <= io_max && (out_req & (io_step - 8'h01)) == 8'h00;
    assign valve_ok = valve_req <= valve_max && (valve_req & (valve_step - 8'h01)) == 8'h00;

    // The bus pin is asynchronous to pclk, so it passes two flip-flops first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_sync1 <= 1'b0;
            bus_ok <= 1'b0;
        end else begin
            bus_sync1 <= fieldbus_ok_pin;
            bus_ok <= bus_sync1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_fault_action <= act_clear;
            soft_action <= sw_clear;
        end else if (factory) begin
            output_fault_action <= act_clear;
            soft_action <= sw_clear;
        end else if (wr && paddr == off_action) begin
            if (pwdata[1:0] <= act_soft) begin
                output_fault_action <= pwdata[1:0];
            end
            if (pwdata[5:4] <= sw_set) begin
                soft_action <= pwdata[5:4];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_size <= input_rst;
            output_size <= output_rst;
            valve_size <= valve_rst;
        end else if (factory) begin
            input_size <= input_rst;
            output_size <= output_rst;
            valve_size <= valve_rst;
        end else if (wr && paddr == off_sizes) begin
            if (in_ok) begin
                input_size <= in_req;
            end
            if (out_ok) begin
                output_size <= out_req;
            end
            if (valve_ok) begin
                valve_size <= valve_req;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wireless_active <= 1'b1;
            order_mode2 <= 1'b0;
            diag_sel <= diag_detailed;
            max_remotes <= remotes_rst;
            refresh_code <= refresh_rst;
        end else if (factory) begin
            wireless_active <= 1'b1;
            order_mode2 <= 1'b0;
            diag_sel <= diag_detailed;
            max_remotes <= remotes_rst;
            refresh_code <= refresh_rst;
        end else if (wr && paddr == off_system) begin
            wireless_active <= pwdata[0];
            order_mode2 <= pwdata[1];
            if (pwdata[5:4] <= diag_detailed) begin
                diag_sel <= pwdata[5:4];
            end
            if (pwdata[12:8] == 5'd0 || pwdata[12:8] == 5'd15 || pwdata[12:8] == 5'd31) begin
                max_remotes <= pwdata[12:8];
            end
            if (pwdata[19:16] <= refresh_last) begin
                refresh_code <= pwdata[19:16];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pairing_pending <= 1'b0;
            pairing_applied <= 1'b0;
        end else if (factory) begin
            pairing_pending <= 1'b0;
            pairing_applied <= 1'b0;
        end else if (reset_module) begin
            pairing_applied <= pairing_pending;
        end else if (wr && paddr == off_control) begin
            pairing_pending <= pwdata[4];
        end
    end

    // tag storage, top byte forced zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < tag_words; i++) begin
                tag_mem[i] <= (i == 0) ? tag_rst_word : 32'h0000_0000;
            end
        end else if (factory) begin
            for (int i = 0; i < tag_words; i++) begin
                tag_mem[i] <= (i == 0) ? tag_rst_word : 32'h0000_0000;
            end
        end else if (wr && paddr >= off_tag0 && paddr < off_tag0 + 8'(4 * tag_words)
            && paddr[1:0] == 2'b00) begin
            if (paddr[3:2] == 2'(tag_words - 1)) begin
                tag_mem[paddr[3:2]] <= {8'h00, pwdata[23:0]};
            end else begin
                tag_mem[paddr[3:2]] <= pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_in <= 9'h000;
            sys_out <= 9'h000;
        end else begin
            sys_in <= {1'b0, input_size} + {1'b0, remote_io_in_points};
            sys_out <= {1'b0, output_size} + {1'b0, remote_io_out_points};
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (paddr == off_action) begin
            next_rdata = {26'h0, soft_action, 2'b00, output_fault_action};
        end else if (paddr == off_sizes) begin
            next_rdata = {8'h00, valve_size, output_size, input_size};
        end else if (paddr == off_system) begin
            next_rdata = {12'h0, refresh_code, 3'h0, max_remotes, 2'b00, diag_sel,
                2'b00, order_mode2, wireless_active};
        end else if (paddr == off_control) begin
            next_rdata = {27'h0, pairing_pending, 4'h0};
        end else if (paddr == off_status) begin
            next_rdata = {29'h0, pairing_applied, wireless_active, bus_ok};
        end else if (paddr == off_sys_size) begin
            next_rdata = {7'h0, sys_out, 7'h0, sys_in};
        end else if (paddr >= off_tag0 && paddr < off_tag0 + 8'(4 * tag_words)) begin
            next_rdata = tag_mem[paddr[3:2]];
        end
    end

    // Reads answer in the first access cycle; pready is high from the first clock after reset.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            prdata <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
            pslverr <= psel && !penable && !known;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            outputs_clear <= 1'b0;
            outputs_hold <= 1'b0;
            outputs_set <= 1'b0;
        end else begin
            outputs_clear <= !bus_ok && (output_fault_action == act_clear
                || (output_fault_action == act_soft && soft_action == sw_clear));
            outputs_hold <= !bus_ok && (output_fault_action == act_hold
                || (output_fault_action == act_soft && soft_action == sw_hold));
            outputs_set <= !bus_ok && output_fault_action == act_soft && soft_action == sw_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wireless_enable <= 1'b0;
            address_order_mode2 <= 1'b0;
            diag_alloc <= diag_none;
            diag_input_offset <= 8'h00;
            channel_valid <= '0;
            refresh_sel <= refresh_rst;
            pairing_active <= 1'b0;
            valve_effective <= 8'h00;
        end else begin
            wireless_enable <= wireless_active;
            address_order_mode2 <= order_mode2;
            diag_alloc <= diag_sel;
            diag_input_offset <= 8'h00;
            channel_valid <= 31'((32'h1 << max_remotes) - 32'h1);
            refresh_sel <= refresh_code;
            pairing_active <= pairing_applied;
            valve_effective <= (valve_size > output_size) ? output_size : valve_size;
        end
    end

    a_valve_limit: assert property (@(posedge pclk) disable iff (!presetn)
        valve_effective <= $past(output_size) && valve_effective <= $past(valve_size))
        else $error("valve points exceed output limit");
    a_size_reject: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == off_sizes && !in_ok) |=> $stable(input_size))
        else $error("bad input size accepted");
    a_pair_staged: assert property (@(posedge pclk) disable iff (!presetn)
        (!reset_module && !factory) |=> $stable(pairing_applied))
        else $error("pairing changed without reset");
    a_fault_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (!bus_ok && output_fault_action == act_clear) |=> outputs_clear)
        else $error("clear action missing");
    a_soft_set: assert property (@(posedge pclk) disable iff (!presetn)
        (!bus_ok && output_fault_action == act_soft && soft_action == sw_set) |=> outputs_set)
        else $error("software set missing");
    a_wireless_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !wireless_active |=> !wireless_enable) else $error("idle link still enabled");
    a_remote_count: assert property (@(posedge pclk) disable iff (!presetn)
        max_remotes == 5'd0 || max_remotes == 5'd15 || max_remotes == 5'd31)
        else $error("illegal remote count");
    a_step_sizes: assert property (@(posedge pclk) disable iff (!presetn)
        input_size[3:0] == 4'h0 && output_size[3:0] == 4'h0 && valve_size[2:0] == 3'h0)
        else $error("size off step");
    a_tag_length: assert property (@(posedge pclk) disable iff (!presetn)
        tag_mem[tag_words - 1][31:24] == 8'h00) else $error("tag over 15 chars");
endmodule // node_cfg

// file: design/node_cfg_pkg.sv
// Constants for the wireless I/O node configuration register bank.
package node_cfg_pkg;
    localparam logic [7:0] off_action = 8'h00;
    localparam logic [7:0] off_sizes = 8'h04;
    localparam logic [7:0] off_system = 8'h08;
    localparam logic [7:0] off_control = 8'h0C;
    localparam logic [7:0] off_status = 8'h10;
    localparam logic [7:0] off_sys_size = 8'h14;
    localparam logic [7:0] off_tag0 = 8'h20;
    localparam int tag_words = 4;
    localparam int tag_chars = 15;
    localparam logic [7:0] io_max = 8'h80;
    localparam logic [7:0] io_step = 8'h10;
    localparam logic [7:0] valve_max = 8'h20;
    localparam logic [7:0] valve_step = 8'h08;
    localparam logic [7:0] input_rst = 8'h80;
    localparam logic [7:0] output_rst = 8'h80;
    localparam logic [7:0] valve_rst = 8'h20;
    localparam logic [4:0] remotes_rst = 5'h0F;
    localparam logic [3:0] refresh_rst = 4'h3;
    localparam logic [3:0] refresh_last = 4'h8;
    // Arbitrary neutral default tag text, standing in for a product number.
    localparam logic [31:0] tag_rst_word = 32'h4E4F_4445;
    typedef enum logic [1:0] {act_clear, act_hold, act_soft} fault_mode_t;
    typedef enum logic [1:0] {sw_clear, sw_hold, sw_set} soft_action_t;
    typedef enum logic [1:0] {diag_none, diag_simple, diag_detailed} diag_mode_t;
endpackage

// file: tb/field_partner.sv
// Model of the fieldbus link and of the remote power seen by the setup tool.
`timescale 1ns/1ps
module field_partner (
    input wire logic pclk,
    input wire logic bus_up,
    input wire logic [7:0] in_pts,
    input wire logic [7:0] out_pts,
    output logic fieldbus_ok_pin,
    output logic [7:0] remote_io_in_points,
    output logic [7:0] remote_io_out_points,
    output logic remote_powered
);
    initial begin
        fieldbus_ok_pin = 1'b1;
        remote_io_in_points = 8'h00;
        remote_io_out_points = 8'h00;
    end
    // The link pin is asynchronous, so it moves well away from the clock edge.
    always @(bus_up) begin
        fieldbus_ok_pin <= #3 bus_up;
    end
    always @(posedge pclk) begin
        remote_io_in_points <= in_pts;
        remote_io_out_points <= out_pts;
    end
    initial remote_powered = 1'b1;
endmodule // field_partner

// file: tb/testbench.sv
// Self-checking bench for the node configuration register bank.
`timescale 1ns/1ps
module testbench;
    import node_cfg_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, w, tw [4];
    logic pready, pslverr, err, fb_ok, powered, o_clr, o_hold, o_set, wl_en, ord2, pair_act;
    logic bus_up = 1'b1;
    logic freeze = 1'b0;
    logic [7:0] in_pts = 8'h00;
    logic [7:0] out_pts = 8'h00;
    logic [7:0] rin, rout, diag_off, valve_eff;
    logic [1:0] diag;
    logic [30:0] chan;
    logic [3:0] rsel;
    int n_fail = 0;
    int compares = 0;
    int seed = 32'h8782e7bd;
    int k, vi, vo, vv;
    int m_in = 128, m_out = 128, m_v = 32, m_act = 0, m_soft = 0;
    int m_wl = 1, m_ord = 0, m_dg = 2, m_rem = 15, m_rf = 3;
    int tbl [4] = '{0, 15, 31, 7};
    logic [31:0] acts [7] = '{32'h0000_0000, 32'h0000_0001, 32'h0000_0002, 32'h0000_0012,
        32'h0000_0022, 32'h0000_0003, 32'h0000_0032};
    initial forever #5 pclk = ~pclk;
    // The remote point counts stay random, but are held still while the map sum is read.
    always @(posedge pclk) begin
        if (!freeze) begin
            in_pts <= 8'($random(seed));
            out_pts <= 8'($random(seed));
        end
    end
    field_partner field_partner_i (.pclk(pclk), .bus_up(bus_up), .in_pts(in_pts),
        .out_pts(out_pts), .fieldbus_ok_pin(fb_ok), .remote_io_in_points(rin),
        .remote_io_out_points(rout), .remote_powered(powered));
    node_cfg node_cfg_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fieldbus_ok_pin(fb_ok), .remote_io_in_points(rin),
        .remote_io_out_points(rout), .outputs_clear(o_clr), .outputs_hold(o_hold),
        .outputs_set(o_set), .wireless_enable(wl_en), .address_order_mode2(ord2),
        .diag_alloc(diag), .diag_input_offset(diag_off), .channel_valid(chan),
        .refresh_sel(rsel), .pairing_active(pair_act), .valve_effective(valve_eff));
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rd);
    endtask
    // Outputs are registered behind the write, and the link pin has a synchroniser.
    task automatic settle();
        repeat (6) @(posedge pclk);
        #1;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        rdchk(off_sizes, 32'h0020_8080, "sizes");
        rdchk(off_system, 32'h0003_0F21, "system");
        rdchk(off_tag0, tag_rst_word, "tag0");
        chk("err", 0, err);
        chk("ports", {1'b1, 1'b0, 2'd2, 4'd3, 8'h20},
            {wl_en, ord2, diag, rsel, valve_eff});
        chk("chan", {1'b0, 31'h0000_7FFF}, {pair_act, chan});
        for (k = 0; k < 24; k++) begin
            vi = ($random(seed) & 15) * 16 + ((k % 7 == 0) ? 8 : 0);
            vo = ($random(seed) & 15) * 16;
            vv = ($random(seed) & 7) * 8 + ((k % 5 == 0) ? 1 : 0);
            if (vi <= 128 && vi % 16 == 0) m_in = vi;
            if (vo <= 128) m_out = vo;
            if (vv <= 32 && vv % 8 == 0) m_v = vv;
            apb(1'b1, off_sizes, {8'h00, 8'(vv), 8'(vo), 8'(vi)});
            rdchk(off_sizes, m_in | m_out << 8 | m_v << 16, "sizes");
            settle();
            chk("valve_eff", (m_v < m_out) ? m_v : m_out, valve_eff);
        end
        for (k = 0; k < 7; k++) begin
            if (acts[k][1:0] != 2'd3) m_act = acts[k][1:0];
            if (acts[k][5:4] != 2'd3) m_soft = acts[k][5:4];
            apb(1'b1, off_action, acts[k]);
            rdchk(off_action, m_act | m_soft << 4, "action");
            bus_up <= 1'b0;
            settle();
            chk("fault", {m_act == 0 || (m_act == 2 && m_soft == 0),
                m_act == 1 || (m_act == 2 && m_soft == 1), m_act == 2 && m_soft == 2},
                {o_clr, o_hold, o_set});
            rdchk(off_status, 32'h0000_0002, "status");
            bus_up <= 1'b1;
            settle();
            chk("fault_off", 0, {o_clr, o_hold, o_set});
        end
        for (k = 0; k < 12; k++) begin
            w = $random(seed);
            w[12:8] = 5'(tbl[k % 4]);
            w[5:4] = 2'(k % 4);
            w[19:16] = 4'(k);
            m_wl = w[0];
            m_ord = w[1];
            if (w[5:4] != 2'd3) m_dg = w[5:4];
            if (w[12:8] == 0 || w[12:8] == 15 || w[12:8] == 31) m_rem = w[12:8];
            if (w[19:16] <= 8) m_rf = w[19:16];
            apb(1'b1, off_system, w);
            rdchk(off_system, m_wl | m_ord << 1 | m_dg << 4 | m_rem << 8 | m_rf << 16,
                "system");
            settle();
            chk("sys_ports", {m_wl[0], m_ord[0], 2'(m_dg), 4'(m_rf), 8'h00},
                {wl_en, ord2, diag, rsel, diag_off});
            chk("chan", (32'h0000_0001 << m_rem) - 32'h0000_0001, {1'b0, chan});
        end
        apb(1'b1, off_control, 32'h0000_0010);
        settle();
        chk("pair_act", 0, pair_act);
        rdchk(off_control, 32'h0000_0010, "control");
        apb(1'b1, off_control, 32'h0000_0002);
        settle();
        chk("pair_act", 1, pair_act);
        apb(1'b1, off_status, 32'h0000_0000);
        rdchk(off_status, 5 | m_wl << 1, "status");
        freeze <= 1'b1;
        settle();
        apb(1'b1, off_sys_size, 32'hFFFF_FFFF);
        rdchk(off_sys_size, (m_out + out_pts) << 16 | (m_in + in_pts), "sys_size");
        freeze <= 1'b0;
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        chk("slverr", 1, err);
        rdchk(8'h40, 32'h0000_0000, "unmapped");
        chk("slverr", 1, err);
        for (k = 0; k < tag_words; k++) begin
            tw[k] = $random(seed);
            if (powered === 1'b1) apb(1'b1, off_tag0 + 8'(4 * k), tw[k]);
        end
        for (k = 0; k < tag_words; k++) begin
            rdchk(off_tag0 + 8'(4 * k), (k == 3) ? tw[k] & 32'h00FF_FFFF : tw[k], "tag");
        end
        apb(1'b1, off_tag0 + 8'h01, 32'hFFFF_FFFF);
        chk("slverr", 1, err);
        rdchk(off_tag0, tw[0], "tag0");
        apb(1'b1, off_control, 32'h0000_0001);
        settle();
        rdchk(off_sizes, 32'h0020_8080, "sizes");
        rdchk(off_action, 32'h0000_0000, "action");
        rdchk(off_system, 32'h0003_0F21, "system");
        rdchk(off_tag0, tag_rst_word, "tag0");
        rdchk(off_status, 32'h0000_0003, "status");
        summarize();
    end
endmodule // testbench
